// *** ldc_config_bank.sv ***
// Upper configuration bank: registers, dimming generator and gate control.
// Notes on behaviour
// - Bin two to four slope factors, defaults 5,2,1.
// - Derating gain code maps off to 0.2.
// - Foldback start 7.5 V plus 0.5 V/code.
// - Dimming enable runs internal dimming; clear hands the switch to the dimming pin.
// - Dimming frequency codes pick 200 to 350 Hz.
// - Duty in 0.5 percent steps, 200 full.
// - Gate drive code picks 25, 2, 0.5, 1 mA.
// - Extra dead time 0, 10, 20, 40 ns.
// - Polarity bit sets high-beam gate, pin low.
// - Force bit holds high-beam gate on.
// - Overvoltage: regulate, or open dimming switch.
// - High-beam overvoltage 20.4 V plus 1.6 V/code.
// - Low-beam overvoltage 10.4 V plus 1.6 V/code.
// - High-beam undervoltage 10.4 V plus 1.6 V/code.
// - Low-beam undervoltage 2.4 V plus 1.6 V/code.
// - Six mask bits route faults to flag two.
// - Dimming pin high without internal dimming: full on.
module ldc_config_bank
	import ldc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regIndirect,
	input  wire logic [7:0]  regDirect,
	input  wire logic [7:0]  regWrData,
	output logic      [7:0]  regRdData,
	output logic             regRdValid,
	input  wire logic        dimmingInputPin,
	input  wire logic        beamSelectPin,
	input  wire logic [5:0]  faultVector,
	output ldc_cfg_s         cfg,
	output logic             highBeamGate,
	output logic             dimmingSwitchGate,
	output logic             overvoltageRegulate,
	output logic             faultFlagTwo_n
);

	logic [NREG-1:0][7:0] words;
	logic [IDX_W:0]       accDec;
	logic                 rdValid_reg;
	ldc_cfg_s             cfg_reg;
	ldc_cfg_s             cfg_next;
	logic [9:0]           presc_reg;
	logic [9:0]           presc_next;
	logic [7:0]           step_reg;
	logic [7:0]           step_next;
	logic                 hbGate_reg;
	logic                 hbGate_next;
	logic                 dimGate_reg;
	logic                 dimGate_next;
	logic                 ovReg_reg;
	logic                 ovReg_next;
	logic                 ff2_reg;
	logic                 ff2_next;

	// Field views of the stored words.
	logic [1:0] freqSel;
	logic [7:0] dutyCode;
	logic [5:0] routeMask;
	logic       dimEnable;
	logic       beamPolarity;
	logic       beamForce;
	logic       ovResponse;
	logic       stepTick;
	logic       dimOn;
	logic       ovCut;
	logic       outOvFault;
	logic [9:0] stepLast;

	// One decode serves both the write strobe and the read strobe.
	assign accDec = ldc_decode(regIndirect, regDirect);

	ldc_reg_mem u_mem (
		.mclk   (mclk),
		.rst    (rst),
		.wrEn   (regWrite && accDec[IDX_W]),
		.wrIdx  (accDec[IDX_W-1:0]),
		.wrData (regWrData),
		.rdEn   (regRead),
		.rdHit  (accDec[IDX_W]),
		.rdIdx  (accDec[IDX_W-1:0]),
		.rdData (regRdData),
		.words  (words)
	);

	// Read data is valid one cycle after the read strobe.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= regRead;
		end
	end

	assign regRdValid = rdValid_reg;

	// Control fields steering the gate logic.
	assign freqSel      = words[IDX_DIMCTL][FREQ_LSB +: 2];
	assign dimEnable    = words[IDX_DIMCTL][DIMEN_BIT];
	assign dutyCode     = words[IDX_DUTY];
	assign beamPolarity = words[IDX_GATE][POL_BIT];
	assign beamForce    = words[IDX_GATE][FORCE_BIT];
	assign ovResponse   = words[IDX_OVHB][OVB_BIT];
	assign routeMask    = words[IDX_FMASK][ROUTE_LSB +: 6];
	assign outOvFault   = faultVector[4];

	assign cfg_next.slope2 = words[IDX_SLOPE2][SLOPE_LSB +: 5];
	assign cfg_next.slope3 = words[IDX_SLOPE3][SLOPE_LSB +: 5];
	assign cfg_next.slope4 = words[IDX_SLOPE4][SLOPE_LSB +: 5];
	assign cfg_next.deratingGain =
		GAIN_TAB[words[IDX_FOLD][GAIN_LSB +: 3]];
	assign cfg_next.foldbackStart = 7'(FOLD_BASE
		+ FOLD_STEP * int'(words[IDX_FOLD][THR_LSB +: 3]));
	assign cfg_next.driveCurrent =
		DRV_TAB[words[IDX_DIMCTL][DRV_LSB +: 2]];
	assign cfg_next.deadTimeNs =
		DEAD_TAB[words[IDX_GATE][DEAD_LSB +: 2]];
	assign cfg_next.ovHigh = 10'(OVHB_BASE
		+ LVL_STEP * int'(words[IDX_OVHB][LVL_LSB +: 5]));
	assign cfg_next.ovLow = 10'(OVLB_BASE
		+ LVL_STEP * int'(words[IDX_OVLB][LVL_LSB +: 5]));
	assign cfg_next.uvHigh = 10'(UVHB_BASE
		+ LVL_STEP * int'(words[IDX_UVHB][LVL_LSB +: 5]));
	assign cfg_next.uvLow = 10'(UVLB_BASE
		+ LVL_STEP * int'(words[IDX_UVLB][LVL_LSB +: 5]));

	// Decoded fields are registered so the outputs never glitch.
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_reg <= '0;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	assign cfg = cfg_reg;

	// step length from the frequency code.
	assign stepLast = 10'(STEP_CYC[freqSel] - 1);
	assign stepTick = (presc_reg >= stepLast);

	// The prescaler and step counter idle at zero while disabled.
	assign presc_next = !dimEnable ? 10'h000 :
		stepTick ? 10'h000 : presc_reg + 10'h001;
	assign step_next = !dimEnable ? 8'h00 :
		!stepTick ? step_reg :
		(step_reg >= 8'(DUTY_STEPS - 1)) ? 8'h00 :
		step_reg + 8'h01;

	// Step counter of the internal dimming generator.
	always_ff @(posedge mclk) begin
		if (rst) begin
			presc_reg <= 10'h000;
			step_reg  <= 8'h00;
		end else begin
			presc_reg <= presc_next;
			step_reg  <= step_next;
		end
	end

	// on while the step lies below the duty code.
	// codes of 200 and above stay on.
	assign dimOn = (dutyCode >= 8'(DUTY_STEPS)) || (step_reg < dutyCode);

	// selected response to an output overvoltage.
	assign ovCut      = outOvFault && ovResponse;
	assign ovReg_next = outOvFault && !ovResponse;

	// internal dimming wins over the pin when enabled.
	// pin high alone gives full brightness.
	assign dimGate_next = ovCut ? 1'b0 :
		dimEnable ? dimOn : dimmingInputPin;

	// force bit first, then the pin.
	assign hbGate_next = beamForce || (beamSelectPin ? 1'b1 : beamPolarity);

	// any routed fault pulls flag two low.
	assign ff2_next = ~|(faultVector & routeMask);

	// Gate and flag outputs.
	always_ff @(posedge mclk) begin
		if (rst) begin
			hbGate_reg  <= 1'b0;
			dimGate_reg <= 1'b0;
			ovReg_reg   <= 1'b0;
			ff2_reg     <= 1'b1;
		end else begin
			hbGate_reg  <= hbGate_next;
			dimGate_reg <= dimGate_next;
			ovReg_reg   <= ovReg_next;
			ff2_reg     <= ff2_next;
		end
	end

	assign highBeamGate        = hbGate_reg;
	assign dimmingSwitchGate   = dimGate_reg;
	assign overvoltageRegulate = ovReg_reg;
	assign faultFlagTwo_n      = ff2_reg;

	// Checks on the behaviour above.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// Reset leaves the documented slope defaults in place.
	property p_slope_rst;
		@(posedge mclk) disable iff (1'b0)
		rst ##1 !rst |=> cfg.slope2 == 5'h05 && cfg.slope3 == 5'h02
			&& cfg.slope4 == 5'h01;
	endproperty
	a_slope_rst: assert property (p_slope_rst)
		else $error("Slope defaults wrong after reset.");

	property p_gain;
		!rst && words[IDX_FOLD][GAIN_LSB +: 3] == 3'h4 |=>
			cfg.deratingGain == 7'h32;
	endproperty
	a_gain: assert property (p_gain)
		else $error("Derating gain code four not half.");

	property p_fold;
		!rst |=> cfg.foldbackStart ==
			7'(FOLD_BASE + FOLD_STEP
			* int'($past(words[IDX_FOLD][THR_LSB +: 3])));
	endproperty
	a_fold: assert property (p_fold)
		else $error("Foldback start does not track code.");

	property p_dim_off;
		!dimEnable && !dimmingInputPin |=> !dimmingSwitchGate;
	endproperty
	a_dim_off: assert property (p_dim_off)
		else $error("Dimming switch on while forced off.");

	sequence s_fullDuty;
		dimEnable && dutyCode >= 8'h c8 && !ovCut;
	endsequence
	property p_full;
		s_fullDuty |=> dimmingSwitchGate;
	endproperty
	a_full: assert property (p_full)
		else $error("Full duty code did not hold switch on.");

	property p_zero;
		dimEnable && dutyCode == 8'h00 |=> !dimmingSwitchGate;
	endproperty
	a_zero: assert property (p_zero)
		else $error("Zero duty still turned switch on.");

	sequence s_forceHeld;
		beamForce [*2];
	endsequence
	property p_force;
		s_forceHeld |=> highBeamGate;
	endproperty
	a_force: assert property (p_force)
		else $error("High-beam gate off while forced.");

	property p_pol;
		!beamForce && !beamSelectPin |=> highBeamGate == $past(beamPolarity);
	endproperty
	a_pol: assert property (p_pol)
		else $error("High-beam gate ignores polarity bit.");

	property p_ovcut;
		outOvFault && ovResponse |=> !dimmingSwitchGate
			&& !overvoltageRegulate;
	endproperty
	a_ovcut: assert property (p_ovcut)
		else $error("Overvoltage did not open the switch.");

	property p_ovhb;
		!rst |=> cfg.ovHigh == 10'(OVHB_BASE + LVL_STEP
			* int'($past(words[IDX_OVHB][LVL_LSB +: 5])));
	endproperty
	a_ovhb: assert property (p_ovhb)
		else $error("High-beam overvoltage level wrong.");

	property p_ff2;
		|(faultVector & routeMask) |=> !faultFlagTwo_n;
	endproperty
	a_ff2: assert property (p_ff2)
		else $error("Routed fault did not reach flag two.");

	property p_rsvd;
		regRdValid && $past(accDec) == {1'b1, IDX_DIMCTL} |->
			regRdData[4:2] == 3'h0;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("Reserved bits read back non-zero.");

	property p_pin_full;
		!rst && !dimEnable && dimmingInputPin && !ovCut |=>
			dimmingSwitchGate;
	endproperty
	a_pin_full: assert property (p_pin_full)
		else $error("Pin high did not give full brightness.");

	// Fixed end points of the level, drive and dead-time tables, so a
	// wrong base or step shows up without repeating the decode.
	property p_ovlb;
		!rst && words[IDX_OVLB][LVL_LSB +: 5] == 5'h1f |=>
			cfg.ovLow == 10'h258;
	endproperty
	a_ovlb: assert property (p_ovlb)
		else $error("Low-beam overvoltage top code not sixty volts.");

	property p_uvhb;
		!rst && words[IDX_UVHB][LVL_LSB +: 5] == 5'h00 |=>
			cfg.uvHigh == 10'h068;
	endproperty
	a_uvhb: assert property (p_uvhb)
		else $error("High-beam undervoltage base level wrong.");

	property p_uvlb;
		!rst && words[IDX_UVLB][LVL_LSB +: 5] == 5'h00 |=>
			cfg.uvLow == 10'h018;
	endproperty
	a_uvlb: assert property (p_uvlb)
		else $error("Low-beam undervoltage base level wrong.");

	property p_drive;
		!rst && words[IDX_DIMCTL][DRV_LSB +: 2] == 2'h0 |=>
			cfg.driveCurrent == 8'hfa;
	endproperty
	a_drive: assert property (p_drive)
		else $error("Gate drive code zero not full current.");

	property p_dead;
		!rst && words[IDX_GATE][DEAD_LSB +: 2] == 2'h3 |=>
			cfg.deadTimeNs == 6'h28;
	endproperty
	a_dead: assert property (p_dead)
		else $error("Dead time code three not longest.");

endmodule

// *** ldc_pkg.sv ***
// Constants, tables and carrier types for the LED configuration bank.
package ldc_pkg;

	// Register file geometry.
	localparam int NREG  = 12;
	localparam int IDX_W = 4;

	// Register indices within the bank.
	localparam logic [3:0] IDX_SLOPE2  = 4'h0;
	localparam logic [3:0] IDX_SLOPE3  = 4'h1;
	localparam logic [3:0] IDX_SLOPE4  = 4'h2;
	localparam logic [3:0] IDX_FOLD    = 4'h3;
	localparam logic [3:0] IDX_DIMCTL  = 4'h4;
	localparam logic [3:0] IDX_DUTY    = 4'h5;
	localparam logic [3:0] IDX_GATE    = 4'h6;
	localparam logic [3:0] IDX_OVHB    = 4'h7;
	localparam logic [3:0] IDX_OVLB    = 4'h8;
	localparam logic [3:0] IDX_UVHB    = 4'h9;
	localparam logic [3:0] IDX_UVLB    = 4'ha;
	localparam logic [3:0] IDX_FMASK   = 4'hb;

	// Indirect and direct address pair of each register.
	localparam logic [15:0] ADDR_TAB [NREG] = '{
		16'h1b06, 16'h1b05, 16'h1c07, 16'h1c06, 16'h1c05, 16'h1d07,
		16'h1d06, 16'h1d05, 16'h1e07, 16'h1e06, 16'h1e05, 16'h1f07};

	// Reset values, reserved bits held at zero.
	localparam logic [7:0] RST_TAB [NREG] = '{
		8'h05, 8'h02, 8'h01, 8'h23, 8'h00, 8'h00,
		8'h00, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'h3f};

	// Writable bits of each register; the rest are reserved.
	localparam logic [7:0] WMASK [NREG] = '{
		8'h1f, 8'h1f, 8'h1f, 8'h3f, 8'he3, 8'hff,
		8'h0f, 8'h3f, 8'h1f, 8'h1f, 8'h1f, 8'h3f};

	// Field positions.
	localparam int SLOPE_LSB = 0;
	localparam int GAIN_LSB  = 3;
	localparam int THR_LSB   = 0;
	localparam int DIMEN_BIT = 7;
	localparam int FREQ_LSB  = 5;
	localparam int DRV_LSB   = 0;
	localparam int DEAD_LSB  = 2;
	localparam int POL_BIT   = 1;
	localparam int FORCE_BIT = 0;
	localparam int OVB_BIT   = 5;
	localparam int LVL_LSB   = 0;
	localparam int ROUTE_LSB = 0;

	// Dimming generator timing.
	localparam int CLK_HZ     = 25_000_000;
	localparam int DUTY_STEPS = 200;
	localparam int FREQ_HZ [4] = '{200, 250, 300, 350};
	localparam int STEP_CYC [4] = '{
		CLK_HZ / (FREQ_HZ[0] * DUTY_STEPS),
		CLK_HZ / (FREQ_HZ[1] * DUTY_STEPS),
		CLK_HZ / (FREQ_HZ[2] * DUTY_STEPS),
		CLK_HZ / (FREQ_HZ[3] * DUTY_STEPS)};

	// Voltages in tenths of a volt.
	localparam int OVHB_BASE = 204;
	localparam int OVLB_BASE = 104;
	localparam int UVHB_BASE = 104;
	localparam int UVLB_BASE = 24;
	localparam int LVL_STEP  = 16;
	localparam int FOLD_BASE = 75;
	localparam int FOLD_STEP = 5;

	// Gain in hundredths, drive in tenths of mA, dead time in ns.
	localparam logic [6:0] GAIN_TAB [8] = '{7'h64, 7'h50, 7'h46, 7'h3c,
		7'h32, 7'h28, 7'h1e, 7'h14};
	localparam logic [7:0] DRV_TAB [4] = '{8'hfa, 8'h14, 8'h05, 8'h0a};
	localparam logic [5:0] DEAD_TAB [4] = '{6'h00, 6'h0a, 6'h14, 6'h28};

	// Decoded configuration handed to the analog side.
	typedef struct packed {
		logic [4:0] slope2;
		logic [4:0] slope3;
		logic [4:0] slope4;
		logic [6:0] deratingGain;
		logic [6:0] foldbackStart;
		logic [7:0] driveCurrent;
		logic [5:0] deadTimeNs;
		logic [9:0] ovHigh;
		logic [9:0] ovLow;
		logic [9:0] uvHigh;
		logic [9:0] uvLow;
	} ldc_cfg_s;

	// Address decode: hit flag above the register index.
	function automatic logic [IDX_W:0] ldc_decode(
		input logic [7:0] ind,
		input logic [7:0] dir);
		logic [IDX_W:0] res;
		res = '0;
		for (int i = 0; i < NREG; i++) begin
			if (ADDR_TAB[i] == {ind, dir}) begin
				res = {1'b1, IDX_W'(i)};
			end
		end
		return res;
	endfunction

endpackage

// *** ldc_reg_mem.sv ***
// Register storage with masked writes and a registered read port.
module ldc_reg_mem
	import ldc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  wrEn,
	input  wire logic [IDX_W-1:0]      wrIdx,
	input  wire logic [7:0]            wrData,
	input  wire logic                  rdEn,
	input  wire logic                  rdHit,
	input  wire logic [IDX_W-1:0]      rdIdx,
	output logic      [7:0]            rdData,
	output logic      [NREG-1:0][7:0]  words
);

	logic [7:0] rdData_reg;

	// Each word resets to its default and drops reserved bits on write.
	// reserved bits dropped.
	for (genvar i = 0; i < NREG; i++) begin : g_word
		always_ff @(posedge mclk) begin
			if (rst) begin
				words[i] <= RST_TAB[i];
			end else if (wrEn && wrIdx == IDX_W'(i)) begin
				words[i] <= wrData & WMASK[i];
			end
		end
	end

	// Read data is captured; unmapped addresses read as zero.
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdData_reg <= 8'h00;
		end else if (rdEn) begin
			rdData_reg <= rdHit ? words[rdIdx] : 8'h00;
		end
	end

	assign rdData = rdData_reg;

endmodule

// *** ldc_host_model.sv ***
// Host model that drives the register port of the configuration bank.
module ldc_host_model (
	input  wire logic       mclk,
	input  wire logic [7:0] regRdData,
	input  wire logic       regRdValid,
	output logic            regWrite,
	output logic            regRead,
	output logic      [7:0] regIndirect,
	output logic      [7:0] regDirect,
	output logic      [7:0] regWrData
);
	timeunit 1ns;
	timeprecision 1ps;

	// Port starts idle with strobes low.
	initial begin
		regWrite = 1'b0;
		regRead = 1'b0;
		regIndirect = 8'h00;
		regDirect = 8'h00;
		regWrData = 8'h00;
	end

	// Released lines are inverted so stale values never look valid.
	task automatic release_bus();
		regIndirect <= ~regIndirect;
		regDirect <= ~regDirect;
		regWrData <= ~regWrData;
	endtask

	// One write strobe held for exactly one sampling edge.
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		regWrite <= 1'b1;
		{regIndirect, regDirect} <= a;
		regWrData <= d;
		@(posedge mclk);
		regWrite <= 1'b0;
		release_bus();
	endtask

	// One read strobe, then the answer is taken at the valid edge.
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		int n;
		@(posedge mclk);
		regRead <= 1'b1;
		{regIndirect, regDirect} <= a;
		@(posedge mclk);
		regRead <= 1'b0;
		release_bus();
		n = 0;
		d = 8'hxx;
		do begin
			@(posedge mclk);
			n++;
		end while (regRdValid !== 1'b1 && n < 4);
		if (regRdValid === 1'b1)
			d = regRdData;
	endtask
endmodule

// *** ldc_config_bank_bench.sv ***
// Self-checking bench for the LED configuration bank.
module ldc_config_bank_bench;
	import ldc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic dimPin = 1'b1;
	logic beamPin = 1'b0;
	logic [5:0] faults = 6'h00;
	logic regWrite, regRead, regRdValid;
	logic [7:0] regIndirect, regDirect, regWrData, regRdData;
	ldc_cfg_s cfg;
	logic highBeamGate, dimSwitch, ovRegulate, faultFlagTwo_n;
	int failures = 0;
	int n_checks = 0;
	logic [7:0] sh [NREG];
	logic [7:0] got, v;
	int run;
	// Expected defaults and writable masks of the twelve registers.
	logic [7:0] rstVal [NREG] = '{8'h05, 8'h02, 8'h01, 8'h23, 8'h00,
		8'h00, 8'h00, 8'h1f, 8'h1f, 8'h00, 8'h00, 8'h3f};
	logic [7:0] wrMask [NREG] = '{8'h1f, 8'h1f, 8'h1f, 8'h3f, 8'he3,
		8'hff, 8'h0f, 8'h3f, 8'h1f, 8'h1f, 8'h1f, 8'h3f};
	int gainH [8] = '{100, 80, 70, 60, 50, 40, 30, 20};
	int drvT [4] = '{250, 20, 5, 10};
	int deadT [4] = '{0, 10, 20, 40};
	int hzT [4] = '{200, 250, 300, 350};

	always #20 mclk = ~mclk;

	ldc_host_model ldc_host_model_i (.mclk(mclk), .regRdData(regRdData),
		.regRdValid(regRdValid), .regWrite(regWrite), .regRead(regRead),
		.regIndirect(regIndirect), .regDirect(regDirect),
		.regWrData(regWrData));

	ldc_config_bank ldc_config_bank_i (.mclk(mclk), .rst(rst),
		.regWrite(regWrite), .regRead(regRead), .regIndirect(regIndirect),
		.regDirect(regDirect), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .dimmingInputPin(dimPin),
		.beamSelectPin(beamPin), .faultVector(faults), .cfg(cfg),
		.highBeamGate(highBeamGate), .dimmingSwitchGate(dimSwitch),
		.overvoltageRegulate(ovRegulate), .faultFlagTwo_n(faultFlagTwo_n));

	// Decoded configuration expected from the shadow registers.
	function automatic ldc_cfg_s exp_cfg();
		ldc_cfg_s c;
		c.slope2 = sh[0][4:0];
		c.slope3 = sh[1][4:0];
		c.slope4 = sh[2][4:0];
		c.deratingGain = 7'(gainH[sh[3][5:3]]);
		c.foldbackStart = 7'(75 + 5 * sh[3][2:0]);
		c.driveCurrent = 8'(drvT[sh[4][1:0]]);
		c.deadTimeNs = 6'(deadT[sh[6][3:2]]);
		c.ovHigh = 10'(204 + 16 * sh[7][4:0]);
		c.ovLow = 10'(104 + 16 * sh[8][4:0]);
		c.uvHigh = 10'(104 + 16 * sh[9][4:0]);
		c.uvLow = 10'(24 + 16 * sh[10][4:0]);
		return c;
	endfunction

	// Compares two values and reports a mismatch at once.
	task automatic chk(input logic [95:0] g, e, input string m);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	// Writes a register and keeps the shadow copy in step.
	task automatic put(input int i, input logic [7:0] d);
		ldc_host_model_i.wr(ADDR_TAB[i], d);
		sh[i] = d & wrMask[i];
	endtask

	// Lets registered outputs follow, then samples mid-cycle.
	task automatic settle();
		repeat (3) @(posedge mclk);
		@(negedge mclk);
	endtask

	task automatic conclude();
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Watchdog sized well beyond the expected run length.
	initial begin
		#(60000 * 40);
		failures++;
		conclude();
	end

	initial begin
		void'($urandom(32'hc614fcc7));
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		// Default values after reset.
		for (int i = 0; i < NREG; i++) begin
			ldc_host_model_i.rd(ADDR_TAB[i], got);
			chk(got, rstVal[i], "reset value");
			sh[i] = rstVal[i];
		end
		settle();
		chk(cfg, exp_cfg(), "default decode");
		// Random writes with random reserved bits, then read back.
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < NREG; i++) begin
				v = 8'($urandom);
				put(i, i == 4 ? v & 8'h7f : v);
				ldc_host_model_i.rd(ADDR_TAB[i], got);
				chk(got, sh[i], "read back");
			end
			settle();
			chk(cfg, exp_cfg(), "decode");
		end
		// Unmapped pair: write ignored, read zero.
		ldc_host_model_i.wr(16'h1f05, 8'hff);
		ldc_host_model_i.rd(16'h1f05, got);
		chk(got, 8'h00, "unmapped");
		// Force, polarity and pin in all combinations.
		for (int c = 0; c < 8; c++) begin
			put(6, {4'h0, 2'(c), c[1], c[0]});
			beamPin <= c[2];
			settle();
			chk(highBeamGate, c[0] | c[2] | c[1], "beam gate");
			chk(cfg.deadTimeNs, deadT[c[1:0]], "dead time");
		end
		// Fault routing and overvoltage response, dimming disabled.
		put(4, 8'h00);
		for (int k = 0; k < 24; k++) begin
			put(11, 8'($urandom));
			put(7, 8'($urandom));
			faults <= 6'($urandom);
			dimPin <= 1'b1;
			settle();
			chk(faultFlagTwo_n, ~|(faults & sh[11][5:0]), "flag two");
			chk(ovRegulate, faults[4] & ~sh[7][5], "ov regulate");
			chk(dimSwitch, !(faults[4] && sh[7][5]), "ov switch");
		end
		// Pin decides while internal dimming is off.
		for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			faults <= 6'h00;
			dimPin <= p[0];
			settle();
			chk(dimSwitch, p[0], "pin dimming");
		end
		// Duty above full scale is on; zero is off over the pin.
		put(5, 8'hff);
		put(4, 8'h80);
		dimPin <= 1'b0;
		settle();
		chk(dimSwitch, 1'b1, "duty over 200");
		put(5, 8'h00);
		dimPin <= 1'b1;
		settle();
		chk(dimSwitch, 1'b0, "duty zero");
		// One duty step at each frequency: high run is one step.
		put(5, 8'h01);
		// Pin low keeps the switch off while the generator is disabled.
		dimPin <= 1'b0;
		for (int f = 0; f < 4; f++) begin
			put(4, 8'h00);
			put(4, 8'h80 | 8'(f << 5) | 8'(f));
			run = 0;
			for (int w = 0; w < 10 && dimSwitch !== 1'b1; w++)
				@(negedge mclk);
			while (dimSwitch === 1'b1 && run < 2000) begin
				@(negedge mclk);
				run++;
			end
			chk(run, 25_000_000 / (hzT[f] * 200), "step length");
			chk(cfg, exp_cfg(), "drive decode");
		end
		conclude();
	end
endmodule
